// *** uelat_top.sv ***
`timescale 1ns/10ps
// How it works
// - An enabled change on the id-ground indication sets latch bit 4, cleared by a read.
// - An enabled change on the session-end indication sets latch bit 3, cleared by a read.
// - An enabled change on session-valid (same as a-device valid) sets bit 2, cleared by a read.
// - An enabled change on the vbus-valid indication sets latch bit 1, cleared by a read.
// - After reset the host-disconnect bit reads 1 when disconnected and 0 when connected.
// - A read-only debug register at offset 0x15 shows live internal signals.
// - Every latch bit clears on a latch read and on entry to low-power, serial or carkit mode.
// - An event coinciding with a latch read appears in the read data and leaves the bit clear.
module uelat_top (
   input wire logic CLK_IN, // 60 MHz interface clock
   input wire logic RST_IN, // sync reset, active high
   input wire uelat_pkg::uelat_events_type EVENTS_IN, // raw indications, async
   input wire logic [uelat_pkg::NUM_EVENTS-1:0] RISE_EN_IN, // rising-edge enables
   input wire logic [uelat_pkg::NUM_EVENTS-1:0] FALL_EN_IN, // falling-edge enables
   input wire logic HOST_MODE_IN, // host mode active
   input wire logic [1:0] LINE_STATE_IN, // usb_line_state, async
   input wire logic LOW_POWER_ENTRY_IN, // pulse: low-power mode entered
   input wire logic SERIAL_ENTRY_IN, // pulse: serial mode entered
   input wire logic CARKIT_ENTRY_IN, // pulse: carkit mode entered
   input wire logic RD_IN, // pulse: register read strobe
   input wire logic [5:0] ADDR_IN, // register address
   output logic [7:0] RDATA_OUT, // read data, registered
   output logic RVALID_OUT // read data valid pulse
);
   localparam int N = uelat_pkg::NUM_EVENTS;

   // ----------------------------------------
   // synchronise inputs
   // ----------------------------------------
   logic [N-1:0] ev_sync;
   logic [1:0] line_sync;
   logic [N-1:0] ev_prev;
   logic edges_live;
   logic [N-1:0] event_hit;
   logic [N-1:0] strap_set;
   logic [N-1:0] set_vec;
   logic [N-1:0] flags;
   logic [N-1:0] next_flags;
   logic latch_read;
   logic debug_read;
   logic mode_clear;

   // warm-up after reset, one step per clock
   typedef enum logic [1:0] {
      warm_fill = 2'b00, // first flop still holds its reset value
      warm_sync = 2'b01, // synchronised copy not yet real
      warm_strap = 2'b11, // real level: take host-disconnect strap
      warm_run = 2'b10 // edge detection live
   } uelat_warm_type;
   uelat_warm_type warm;
   uelat_warm_type next_warm;

   uelat_sync #(.WIDTH(N)) ev_sync_i (
      .CLK_IN(CLK_IN),
      .RST_IN(RST_IN),
      .D_IN(EVENTS_IN),
      .Q_OUT(ev_sync)
   );

   uelat_sync #(.WIDTH(2)) line_sync_i (
      .CLK_IN(CLK_IN),
      .RST_IN(RST_IN),
      .D_IN(LINE_STATE_IN),
      .Q_OUT(line_sync)
   );

   // ----------------------------------------
   // edge detection
   // ----------------------------------------
   // previous level, compared only once both copies are real
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ev_prev <= '0;
      end else begin
         ev_prev <= ev_sync;
      end
   end

   // no edges until the pipeline holds real levels: avoids false edges
   always_comb begin
      case (warm)
         warm_fill: begin
            next_warm = warm_sync;
         end
         warm_sync: begin
            next_warm = warm_strap;
         end
         warm_strap: begin
            next_warm = warm_run;
         end
         warm_run: begin
            next_warm = warm_run;
         end
         default: begin
            next_warm = warm_fill;
         end
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         warm <= warm_fill;
      end else begin
         warm <= next_warm;
      end
   end

   assign edges_live = (warm == warm_run);

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_edge
         if (g == uelat_pkg::HOSTDIS_BIT) begin : g_host
            assign event_hit[g] = edges_live && HOST_MODE_IN &&
               ((RISE_EN_IN[g] && ev_sync[g] && !ev_prev[g]) ||
                (FALL_EN_IN[g] && !ev_sync[g] && ev_prev[g]));
         end else begin : g_other
            assign event_hit[g] = edges_live &&
               ((RISE_EN_IN[g] && ev_sync[g] && !ev_prev[g]) ||
                (FALL_EN_IN[g] && !ev_sync[g] && ev_prev[g]));
         end
      end
   endgenerate

   // ----------------------------------------
   // latch flags
   // ----------------------------------------
   // read strobe aimed at one register offset
   function automatic logic reg_hit(input logic rd, input logic [5:0] addr,
         input logic [5:0] offset);
      return rd && (addr == offset);
   endfunction

   assign latch_read = reg_hit(RD_IN, ADDR_IN, uelat_pkg::LATCH_OFFSET);
   assign debug_read = reg_hit(RD_IN, ADDR_IN, uelat_pkg::DEBUG_OFFSET);
   assign mode_clear = LOW_POWER_ENTRY_IN || SERIAL_ENTRY_IN || CARKIT_ENTRY_IN;

   // host-disconnect level taken once, treated like an enabled event
   always_comb begin
      strap_set = '0;
      if (warm == warm_strap) begin
         strap_set[uelat_pkg::HOSTDIS_BIT] = ev_sync[uelat_pkg::HOSTDIS_BIT];
      end
   end

   assign set_vec = event_hit | strap_set;

   always_comb begin
      next_flags = flags | set_vec;
      if (latch_read || mode_clear) begin
         next_flags = '0;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         flags <= uelat_pkg::LATCH_RESET[N-1:0];
      end else begin
         flags <= next_flags;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         RDATA_OUT <= 8'h00;
         RVALID_OUT <= 1'b0;
      end else begin
         RVALID_OUT <= RD_IN;
         if (!RD_IN) begin
            RDATA_OUT <= 8'h00;
         end else if (latch_read) begin
            RDATA_OUT <= {3'h0, flags | set_vec};
         end else if (debug_read) begin
            RDATA_OUT <= {6'h00, line_sync};
         end else begin
            RDATA_OUT <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   id_ground_set_a: assert property (event_hit[4] && !latch_read && !mode_clear |=> flags[4])
      else $error("id ground flag not set");
   sess_end_set_a: assert property (event_hit[3] && !latch_read && !mode_clear |=> flags[3])
      else $error("session end flag not set");
   sess_valid_set_a: assert property (event_hit[2] && !latch_read && !mode_clear |=> flags[2])
      else $error("session valid flag not set");
   vbus_set_a: assert property (event_hit[1] && !latch_read && !mode_clear |=> flags[1])
      else $error("vbus flag not set");
   hostdis_set_a: assert property (event_hit[0] && !latch_read && !mode_clear |=> flags[0])
      else $error("host disconnect flag not set");
   host_only_a: assert property (!HOST_MODE_IN && edges_live && !flags[0]
      |=> !flags[0])
      else $error("host disconnect set outside host mode");
   strap_a: assert property (warm == warm_strap && !latch_read && !mode_clear
      |=> flags[uelat_pkg::HOSTDIS_BIT] == $past(ev_sync[uelat_pkg::HOSTDIS_BIT]))
      else $error("host disconnect strap wrong");
   sticky_a: assert property (!latch_read && !mode_clear
      |=> (flags & $past(flags)) == $past(flags))
      else $error("latch flag lost without a clear");
   held_flag_read_a: assert property (latch_read
      |=> RVALID_OUT && (RDATA_OUT[4:0] & $past(flags)) == $past(flags))
      else $error("set flag missing from read data");
   debug_read_a: assert property (RD_IN && ADDR_IN == uelat_pkg::DEBUG_OFFSET
      |=> RVALID_OUT && RDATA_OUT[1:0] == $past(line_sync))
      else $error("debug read data wrong");
   debug_zero_a: assert property (RD_IN && ADDR_IN == uelat_pkg::DEBUG_OFFSET
      |=> RDATA_OUT[7:2] == 6'h00)
      else $error("debug upper bits not zero");
   clear_all_a: assert property (latch_read || mode_clear |=> flags == '0)
      else $error("latch not cleared");
   same_cycle_a: assert property (latch_read && event_hit[1]
      |=> RDATA_OUT[1] && !flags[1])
      else $error("coinciding event mishandled");

   latch_read_c: cover property (flags != '0 ##1 latch_read);
   event_read_c: cover property (latch_read && event_hit != '0);
   mode_clear_c: cover property (flags != '0 && mode_clear);
   debug_c: cover property (RD_IN && ADDR_IN == uelat_pkg::DEBUG_OFFSET && line_sync != 2'h0);
   strap_c: cover property (warm == warm_strap && ev_sync[uelat_pkg::HOSTDIS_BIT]);
endmodule

// *** uelat_pkg.sv ***
package uelat_pkg;
   localparam logic [5:0] LATCH_OFFSET = 6'h14;
   localparam logic [5:0] DEBUG_OFFSET = 6'h15;
   localparam int HOSTDIS_BIT = 0;
   localparam int VBUS_BIT = 1;
   localparam int SESSION_VALID_INDICATION_BIT = 2;
   localparam int SESSION_END_INDICATION_BIT = 3;
   localparam int ID_GROUND_INDICATION_BIT = 4;
   localparam int NUM_EVENTS = 5;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [1:0] LINE_STATE_RESET = 2'h0;

   // raw event indications from the analog comparators
   typedef struct packed {
      logic id_ground_indication;
      logic session_end_indication;
      logic session_valid_indication;
      logic vbus_valid_indication;
      logic host_disconnect_indication;
   } uelat_events_type;
endpackage

// *** uelat_sync.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// two-flop synchroniser, vector width
// ----------------------------------------
module uelat_sync #(
   parameter int WIDTH = 1
) (
   input wire logic CLK_IN, // clock
   input wire logic RST_IN, // sync reset
   input wire logic [WIDTH-1:0] D_IN, // async input
   output logic [WIDTH-1:0] Q_OUT // synchronised output
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         meta <= '0;
         Q_OUT <= '0;
      end else begin
         meta <= D_IN;
         Q_OUT <= meta;
      end
   end
endmodule

// *** uelat_link.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// link controller side: register reads
// ----------------------------------------
module uelat_link (
   input wire logic clk_in, // clock
   input wire logic rvalid_in, // read data valid
   input wire logic [7:0] rdata_in, // read data
   output logic rd_out, // read strobe
   output logic [5:0] addr_out // register address
);
   initial begin
      rd_out = 1'b0;
      addr_out = 6'h3F;
   end
   // one read: strobe for one edge, data taken while valid stands
   task automatic read(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_in);
      #1;
      rd_out = 1'b1;
      addr_out = a;
      @(posedge clk_in);
      #1;
      rd_out = 1'b0;
      addr_out = ~a;
      d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
   endtask
endmodule

// *** uelat_top_bench.sv ***
`timescale 1ns/10ps
module uelat_top_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   uelat_pkg::uelat_events_type ev = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   logic [4:0] rise_en = 5'h1F;
   logic [4:0] fall_en = 5'h00;
   logic host = 1'b1;
   logic [1:0] ls = 2'h0;
   logic [2:0] entry = 3'h0;
   logic rd, rvalid;
   logic [5:0] addr;
   logic [7:0] rdata, d;
   int fails = 0;
   int num_checks = 0;
   always #5 clk = ~clk;
   uelat_top dut (.CLK_IN(clk), .RST_IN(rst), .EVENTS_IN(ev), .RISE_EN_IN(rise_en),
      .FALL_EN_IN(fall_en), .HOST_MODE_IN(host), .LINE_STATE_IN(ls),
      .LOW_POWER_ENTRY_IN(entry[0]), .SERIAL_ENTRY_IN(entry[1]),
      .CARKIT_ENTRY_IN(entry[2]), .RD_IN(rd), .ADDR_IN(addr),
      .RDATA_OUT(rdata), .RVALID_OUT(rvalid));
   uelat_link link (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata), .rd_out(rd),
      .addr_out(addr));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic strap_and_clear();
      link.read(uelat_pkg::LATCH_OFFSET, d);
      check("latch after reset", 8'h01, d);
      link.read(uelat_pkg::LATCH_OFFSET, d);
      check("latch reread", 8'h00, d);
      ev = '0;
      settle();
   endtask
   task automatic each_event();
      for (int i = 0; i < 5; i++) begin
         ev[i] = 1'b1;
         settle();
         link.read(uelat_pkg::LATCH_OFFSET, d);
         check("latch event", 8'h01 << i, d);
         ev[i] = 1'b0;
         settle();
         link.read(uelat_pkg::LATCH_OFFSET, d);
         check("latch masked fall", 8'h00, d);
      end
   endtask
   task automatic host_off();
      host = 1'b0;
      ev[0] = 1'b1;
      settle();
      link.read(uelat_pkg::LATCH_OFFSET, d);
      check("latch device mode", 8'h00, d);
      host = 1'b1;
      fall_en = 5'h1F;
   endtask
   task automatic mode_entry();
      for (int m = 0; m < 3; m++) begin
         ev[4] = ~ev[4];
         settle();
         entry[m] = 1'b1;
         @(posedge clk);
         #1;
         entry[m] = 1'b0;
         link.read(uelat_pkg::LATCH_OFFSET, d);
         check("latch after mode entry", 8'h00, d);
      end
   endtask
   task automatic debug_reads();
      for (int s = 0; s < 4; s++) begin
         ls = s[1:0];
         settle();
         link.read(uelat_pkg::DEBUG_OFFSET, d);
         check("debug", {6'h00, s[1:0]}, d);
      end
      link.read(6'h20, d);
      check("unmapped", 8'h00, d);
   endtask
   task automatic masks_and_same_cycle();
      rise_en = 5'h00;
      ev[3] = 1'b1;
      settle();
      link.read(uelat_pkg::LATCH_OFFSET, d);
      check("latch masked rise", 8'h00, d);
      ev[3] = 1'b0;
      settle();
      link.read(uelat_pkg::LATCH_OFFSET, d);
      check("latch enabled fall", 8'h08, d);
      rise_en = 5'h1F;
      ev[1] = 1'b1;
      @(posedge clk);
      #1;
      link.read(uelat_pkg::LATCH_OFFSET, d);
      check("latch same cycle", 8'h02, d);
      link.read(uelat_pkg::LATCH_OFFSET, d);
      check("latch after same cycle", 8'h00, d);
   endtask
   task automatic reset_strap();
      ev[0] = 1'b0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      settle();
      link.read(uelat_pkg::LATCH_OFFSET, d);
      check("latch after reset connected", 8'h00, d);
   endtask
   initial begin
      #20000;
      fails++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      settle();
      strap_and_clear();
      each_event();
      host_off();
      mode_entry();
      masks_and_same_cycle();
      debug_reads();
      reset_strap();
      give_verdict();
   end
endmodule
